// file: rtl/rafcfg_pkg.sv
// Package with register map, field positions and carrier types for the aux config and fault flags
package rafcfg_pkg;

  localparam logic [7:0] RAFCFG_AUX_CONFIG_ADDR  = 8'h03;
  localparam logic [7:0] RAFCFG_FAULT_FLAGS_ADDR = 8'h04;

  localparam logic [7:0] RAFCFG_AUX_CONFIG_RST   = 8'h00;
  localparam logic [7:0] RAFCFG_FAULT_FLAGS_RST  = 8'h02;
  localparam logic [7:0] RAFCFG_AUX_CONFIG_WMASK = 8'h03;

  localparam int RAFCFG_STANDALONE_BIT  = 1;
  localparam int RAFCFG_BLANK_BIT       = 0;
  localparam int RAFCFG_N_FLAGS         = 6;

  localparam logic [1:0] RAFCFG_RDATA_LAT = 2'h1;

  // Register access from the serial slave, same clock domain
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rafcfg_req_t;

  // Fault event pulses, one per status bit 5..0
  typedef struct packed {
    logic hiccup;
    logic overcurrent;
    logic overtemp_warning;
    logic overtemp_shutdown;
    logic undervoltage;
    logic overvoltage;
  } rafcfg_evt_t;

endpackage : rafcfg_pkg

// file: rtl/rafcfg_sync.sv
// Two-flop synchroniser bank for asynchronous level inputs
`timescale 1ns/1ps
module rafcfg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : rafcfg_sync

// file: rtl/rafcfg_regs.sv
// Aux config register and read-clear fault flags register with their pin effects
`timescale 1ns/1ps

// How it works
// - aux_config bit 1 set disables enable-pin pulldown and sync clock output, clear enables both.
// - aux_config bit 0 set floats output_ok_pin during voltage ramps, clear follows the comparator.
// - Hiccup flag bit 5 latches the event until the next status read, reset zero.
// - Overcurrent flag bit 4 latches the event until the next status read, reset zero.
// - Overtemp warning flag bit 3 latches the event until the next status read, reset zero.
// - Overtemp shutdown flag bit 2 latches the event until the next status read, reset zero.
// - Undervoltage flag bit 1 latches until read and resets to one, so status reads 02h.
// - Overvoltage flag bit 0 latches the event until the next status read, reset zero.
module rafcfg_regs import rafcfg_pkg::*; (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire rafcfg_req_t req,
  input  wire rafcfg_evt_t evt,
  input  wire logic        window_ok_async,
  input  wire logic        voltage_ramp_transition_async,
  output logic [7:0]       rdata,
  output logic             rvalid,
  output logic             en_pulldown_on,
  output logic             sync_out_on,
  output logic             output_ok_pin_o,
  output logic             output_ok_pin_oe
);

  logic [1:0] pin_sync;
  logic       window_ok;
  logic       voltage_ramp_transition;

  rafcfg_sync #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({window_ok_async, voltage_ramp_transition_async}),
    .sync_out (pin_sync)
  );

  assign window_ok               = pin_sync[1];
  assign voltage_ramp_transition = pin_sync[0];

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_addr);
    addr_hit = (a == ref_addr);
  endfunction : addr_hit

  // Config register state
  logic [7:0]                aux_config_reg;
  logic [7:0]                aux_config_next;
  logic                      aux_wr_hit;
  logic                      aux_rd_hit;

  // Fault flag state, one flop per flag
  logic [7:0]                fault_flags_word;
  logic [RAFCFG_N_FLAGS-1:0] evt_vec;
  logic [RAFCFG_N_FLAGS-1:0] flag_q;
  logic                      flags_read;

  // Read port state
  logic [7:0]                rdata_reg;
  logic [7:0]                rdata_next;
  logic                      rvalid_reg;
  logic                      rvalid_next;

  // Enable-pin pulldown and sync output state
  logic                      standalone;
  logic                      en_pulldown_reg;
  logic                      en_pulldown_next;
  logic                      sync_out_reg;
  logic                      sync_out_next;

  // Output ok pin state
  logic                      blank_now;
  logic                      ok_o_reg;
  logic                      ok_o_next;
  logic                      ok_oe_reg;
  logic                      ok_oe_next;

  // Strobe decode shared by the groups
  assign evt_vec    = evt;
  assign aux_wr_hit = req.wr_en && addr_hit(req.addr, RAFCFG_AUX_CONFIG_ADDR);
  assign aux_rd_hit = req.rd_en && addr_hit(req.addr, RAFCFG_AUX_CONFIG_ADDR);
  assign flags_read = req.rd_en && addr_hit(req.addr, RAFCFG_FAULT_FLAGS_ADDR);

  // Config register, reserved bits never stored
  always_comb begin
    aux_config_next = aux_config_reg;
    if (aux_wr_hit) begin
      aux_config_next = req.wdata & RAFCFG_AUX_CONFIG_WMASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aux_config_reg <= RAFCFG_AUX_CONFIG_RST;
    end else begin
      aux_config_reg <= aux_config_next;
    end
  end

  // Sticky flags: a read drops a flag, an event in the same cycle wins
  for (genvar gi = 0; gi < RAFCFG_N_FLAGS; gi++) begin : g_flag
    logic flag_reg;
    logic flag_next;

    // Clear on read first, then let an event set it
    always_comb begin
      flag_next = flag_reg;
      if (flags_read) begin
        flag_next = 1'b0;
      end
      if (evt_vec[gi]) begin
        flag_next = 1'b1;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        flag_reg <= RAFCFG_FAULT_FLAGS_RST[gi];
      end else begin
        flag_reg <= flag_next;
      end
    end

    assign flag_q[gi] = flag_reg;
  end

  // Reserved upper bits read zero
  assign fault_flags_word = {{(8 - RAFCFG_N_FLAGS){1'b0}}, flag_q};

  // Read strobe answered one cycle later
  always_comb begin
    rvalid_next = req.rd_en;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rvalid_next;
    end
  end

  // Read data stands for the one cycle after the strobe
  always_comb begin
    // Unmapped reads return zero
    rdata_next = 8'h00;
    if (aux_rd_hit) begin
      rdata_next = aux_config_reg;
    end else if (flags_read) begin
      rdata_next = fault_flags_word;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Standalone operation turns both functions off together
  assign standalone = aux_config_reg[RAFCFG_STANDALONE_BIT];

  always_comb begin
    en_pulldown_next = !standalone;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_pulldown_reg <= !RAFCFG_AUX_CONFIG_RST[RAFCFG_STANDALONE_BIT];
    end else begin
      en_pulldown_reg <= en_pulldown_next;
    end
  end

  always_comb begin
    sync_out_next = !standalone;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_out_reg <= !RAFCFG_AUX_CONFIG_RST[RAFCFG_STANDALONE_BIT];
    end else begin
      sync_out_reg <= sync_out_next;
    end
  end

  // Blanking only while a ramp is in progress
  assign blank_now = aux_config_reg[RAFCFG_BLANK_BIT] && voltage_ramp_transition;

  // Open drain: pulled low while the window reports not ok and blank_now is clear
  always_comb begin
    ok_o_next  = 1'b0;
    ok_oe_next = !window_ok && !blank_now;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ok_o_reg  <= 1'b0;
      ok_oe_reg <= 1'b1;
    end else begin
      ok_o_reg  <= ok_o_next;
      ok_oe_reg <= ok_oe_next;
    end
  end

  // Every output straight from a flop
  assign rdata            = rdata_reg;
  assign rvalid           = rvalid_reg;
  assign en_pulldown_on   = en_pulldown_reg;
  assign sync_out_on      = sync_out_reg;
  assign output_ok_pin_o  = ok_o_reg;
  assign output_ok_pin_oe = ok_oe_reg;

endmodule : rafcfg_regs

// file: bench/rafcfg_assertions.sv
// Checker for the aux config and fault flags register block
`timescale 1ns/1ps
module rafcfg_chk import rafcfg_pkg::*; (
  input wire logic        clk,
  input wire logic        nrst,
  input wire rafcfg_req_t req,
  input wire rafcfg_evt_t evt,
  input wire logic        window_ok_async,
  input wire logic        voltage_ramp_transition_async,
  input wire logic [7:0]  rdata,
  input wire logic        rvalid,
  input wire logic        en_pulldown_on,
  input wire logic        sync_out_on,
  input wire logic        output_ok_pin_o,
  input wire logic        output_ok_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd4; req.rd_en && req.addr == 8'h04; endsequence
  sequence s_wr3; req.wr_en && req.addr == 8'h03 ##1 !req.wr_en; endsequence
  chk_aux_rsvd: assert property (rvalid && $past(req.addr) == 8'h03 |-> rdata[7:2] == 6'h00)
    else $error("aux reserved bits set");
  chk_single_off: assert property (s_wr3 |=> en_pulldown_on == !$past(req.wdata[1], 2))
    else $error("pulldown wrong after write");
  chk_pins_pair: assert property (en_pulldown_on == sync_out_on)
    else $error("pulldown and sync out differ");
  chk_pg_pull: assert property ((!window_ok_async && !voltage_ramp_transition_async)[*4]
    |-> output_ok_pin_oe && !output_ok_pin_o)
    else $error("output ok not pulled low");
  chk_stat_rsvd: assert property (rvalid && $past(req.addr) == 8'h04 |-> rdata[7:6] == 2'h0)
    else $error("status reserved bits set");
  chk_flag_held: assert property (evt.hiccup ##1 s_rd4 |=> rdata[5])
    else $error("hiccup flag lost");
  chk_read_clear: assert property ((s_rd4 and evt == 6'h00) ##1 (!req.rd_en && evt == 6'h00)
    ##1 s_rd4 |=> rdata[5:0] == 6'h00)
    else $error("flags not cleared by read");
  chk_evt_kept: assert property ((s_rd4 and evt.overvoltage) ##1 !req.rd_en ##1 s_rd4
    |=> rdata[0])
    else $error("event lost at read");
endmodule : rafcfg_chk

// file: bench/rafcfg_host.sv
// Host model issuing register reads and writes
`timescale 1ns/1ps
module rafcfg_host import rafcfg_pkg::*; (
  input  wire logic       clk,
  output rafcfg_req_t     req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req <= '{1'b1, 1'b0, a, v & 8'h03};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    v = rvalid ? rdata : 'x;
  endtask : rd
endmodule : rafcfg_host

// file: bench/testbench.sv
// Testbench for the aux config and fault flags register block
`timescale 1ns/1ps
module testbench import rafcfg_pkg::*;;
  logic        clk = 0, nrst = 0, win = 0, ramp = 0, rv, pd, so, pg_o, pg_oe;
  rafcfg_req_t req;
  rafcfg_evt_t evt = '0;
  logic [7:0]  rdata, d;
  int          bad_count = 0, check_count = 0;
  always #5 clk = ~clk;
  rafcfg_host host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rv));
  rafcfg_regs dut_u (.clk(clk), .nrst(nrst), .req(req), .evt(evt), .window_ok_async(win),
    .voltage_ramp_transition_async(ramp), .rdata(rdata), .rvalid(rv), .en_pulldown_on(pd),
    .sync_out_on(so), .output_ok_pin_o(pg_o), .output_ok_pin_oe(pg_oe));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    #20000;
    bad_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    host_u.rd(8'h04, d); cmp("flags", 8'h02, d);
    host_u.rd(8'h04, d); cmp("flags", 8'h00, d);
    host_u.rd(8'h03, d); cmp("aux", 8'h00, d);
    cmp("pins", 4'hd, {pd, so, pg_o, pg_oe});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      evt <= 6'h01 << i;
      @(posedge clk);
      evt <= '0;
      host_u.rd(8'h04, d); cmp("flag", 8'h01 << i, d);
      host_u.rd(8'h04, d); cmp("flag", 8'h00, d);
    end
    $display("test events done");
    host_u.wr(8'h03, 8'hff);
    host_u.rd(8'h03, d); cmp("aux", 8'h03, d);
    cmp("pins", 2'h0, {pd, so});
    ramp <= 1;
    repeat (5) @(posedge clk);
    cmp("oe", 1'b0, pg_oe);
    ramp <= 0;
    repeat (5) @(posedge clk);
    cmp("oe", 1'b1, pg_oe);
    host_u.wr(8'h03, 8'h00);
    win <= 1;
    repeat (5) @(posedge clk);
    cmp("pins", 3'h6, {pd, so, pg_oe});
    $display("test config done");
    host_u.rd(8'h10, d); cmp("unmapped", 8'h00, d);
    host_u.wr(8'h04, 8'hff);
    host_u.rd(8'h04, d); cmp("flags", 8'h00, d);
    evt <= 6'h01;
    fork
      host_u.rd(8'h04, d);
      begin @(posedge clk); evt <= '0; end
    join
    cmp("flags", 8'h00, d);
    host_u.rd(8'h04, d); cmp("flags", 8'h01, d);
    $display("test access done");
    nrst <= 0;
    @(posedge clk);
    nrst <= 1;
    host_u.rd(8'h04, d); cmp("flags", 8'h02, d);
    host_u.rd(8'h03, d); cmp("aux", 8'h00, d);
    $display("test second reset done");
    results();
  end
endmodule : testbench
bind rafcfg_regs rafcfg_chk chk_u (.clk(clk), .nrst(nrst), .req(req), .evt(evt),
  .window_ok_async(window_ok_async), .voltage_ramp_transition_async(voltage_ramp_transition_async),
  .rdata(rdata), .rvalid(rvalid), .en_pulldown_on(en_pulldown_on), .sync_out_on(sync_out_on),
  .output_ok_pin_o(output_ok_pin_o), .output_ok_pin_oe(output_ok_pin_oe));
